// ==== shared/dcr_pkg.sv ====
package dcr_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_SEL = 8'h08;
	localparam logic [7:0] ADR_LO = 8'h0c;
	localparam logic [7:0] ADR_HI = 8'h10;
	localparam logic [7:0] ADR_RATE = 8'h14;
	// Bus responses
	localparam logic [1:0] RSP_OK = 2'h0;
	localparam logic [1:0] RSP_ERR = 2'h2;
	// Control register fields
	localparam int C_LVL = 0;
	localparam int C_CASP = 4;
	localparam int C_CASA = 5;
	localparam int C_CIRC = 6;
	localparam int C_TERM = 8;
	localparam int C_VER = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Capability report field positions, index 55 is bit 1
	localparam int R_LVL = 53;
	localparam int R_PEAK = 49;
	localparam int R_AVG = 45;
	localparam int R_CASP = 44;
	localparam int R_CASA = 43;
	localparam int R_CIRC = 42;
	localparam int R_SS = 31;
	localparam int R_TERM = 27;
	localparam int R_VER = 20;
	// Downlink register numbers
	localparam logic [7:0] REG_CAP = 8'h10;
	localparam logic [7:0] REG_LOADED = 8'h17;
	localparam logic [7:0] REG_INST0 = 8'h18;
	localparam logic [7:0] REG_INST4 = 8'h1c;
	localparam logic [7:0] REG_DGRAM0 = 8'h1d;
	localparam logic [7:0] REG_DGRAM2 = 8'h1f;
	// Installed flags that do not count as specific services: 10, 20, 30
	localparam logic [279:0] SS_EXCL = 280'h1_0001_0001_0000;
	// Capability levels
	localparam logic [2:0] LVL_2 = 3'h2;
	localparam logic [2:0] LVL_3 = 3'h3;
	localparam logic [2:0] LVL_4 = 3'h4;
	localparam logic [2:0] LVL_5 = 3'h5;
	// Air interrogation kinds
	localparam logic [2:0] K_SURV = 3'h0;
	localparam logic [2:0] K_SHORT_UP = 3'h1;
	localparam logic [2:0] K_SHORT_DN = 3'h2;
	localparam logic [2:0] K_EXT_UP = 3'h3;
	localparam logic [2:0] K_EXT_DN = 3'h4;
	localparam logic [2:0] K_RDREG = 3'h5;
endpackage

// ==== hw/dcr_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Level two and up: short messages both ways
// - Level three adds extended-length uplink acceptance
// - Level four adds extended-length downlink too
// - Level five serves several interrogators concurrently
// - Report holds level, rates, collision unit, services
// - Bit 25 set when any specific service installed
// - Registers 18 to 1C flag installed registers
// - Register 17 flags registers holding useful data
// - Registers 1D to 1F flag datagram services
// - Report carries terminal equipment status
// - Report carries subnetwork version number
// - Rate capability from connector pins, self-updating
// - Any report change, link loss too, is broadcast
// - Reply withheld for unequipped service requests
// - Reply to uplink messages withheld when no message storage free
// - 255 read-only 56-bit downlink registers
module dcr_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] rate_peak_pin,
	input wire logic [3:0] rate_avg_pin,
	input wire logic link_fail_pin,
	input wire logic ir_valid,
	input wire logic [2:0] ir_kind,
	input wire logic [7:0] ir_reg,
	input wire logic ir_other_busy,
	input wire logic ir_store_ok,
	output logic rp_valid,
	output logic rp_reply,
	output logic [55:0] rp_data,
	output logic bc_valid,
	output logic [55:0] bc_data,
	input wire logic bc_ready
);
	// Downlink register store, entry 0 unused
	logic [55:0] mem [1:255];
	logic [55:0] inst_reg [0:4]; // Shadow of installed-flag registers
	logic [31:0] ctrl_reg; // Level and service configuration
	logic [7:0] sel_reg; // Register chosen for software load
	logic [31:0] lo_reg; // Staged low word
	logic [23:0] hi_reg; // Staged high bits
	logic [8:0] sync1_reg; // First synchroniser stage
	logic [8:0] sync2_reg; // Second stage, safe to read
	logic [55:0] report; // Assembled capability report
	logic [55:0] ann_reg; // Last announced report
	logic bc_pend_reg; // Broadcast offered, not yet taken
	logic [55:0] bc_data_reg;
	logic rp_valid_reg;
	logic rp_reply_reg;
	logic [55:0] rp_data_reg;
	logic aw_have_reg; // Write address held
	logic w_have_reg; // Write data held
	logic [7:0] aw_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic do_wr; // Both halves of a write present
	logic [2:0] lvl;
	logic link_fail;
	logic ss_flag;
	logic [31:0] hi_merge; // High word with the write's lanes merged
	logic [31:0] sel_merge; // Select word with the write's lanes merged

	// Merge byte lanes of a write into the old word
	function automatic logic [31:0] strb_fn(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Decide whether an interrogation earns a reply
	function automatic logic ok_fn(input logic [2:0] k,
		input logic [2:0] lv, input logic st, input logic busy,
		input logic [7:0] rg);
		logic ok;
		ok = 1'b1;
		unique case (k)
			dcr_pkg::K_SURV: ok = 1'b1;
			dcr_pkg::K_SHORT_UP, dcr_pkg::K_SHORT_DN: begin
				ok = (lv >= dcr_pkg::LVL_2);
			end
			dcr_pkg::K_EXT_UP: ok = (lv >= dcr_pkg::LVL_3);
			dcr_pkg::K_EXT_DN: ok = (lv >= dcr_pkg::LVL_4);
			dcr_pkg::K_RDREG: ok = (rg != 8'h00);
			default: ok = 1'b0;
		endcase
		// Storage is needed only for uplink message fields
		if ((k == dcr_pkg::K_SHORT_UP || k == dcr_pkg::K_EXT_UP)
			&& !st) begin
			ok = 1'b0;
		end
		// Below level five a busy link answers only surveillance and register reads
		if (k != dcr_pkg::K_SURV && k != dcr_pkg::K_RDREG && busy
			&& lv != dcr_pkg::LVL_5) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// Pins cross into the clock domain through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 9'h000;
			sync2_reg <= 9'h000;
		end else begin
			sync1_reg <= {link_fail_pin, rate_peak_pin, rate_avg_pin};
			sync2_reg <= sync1_reg;
		end
	end

	assign link_fail = sync2_reg[8];
	assign lvl = ctrl_reg[dcr_pkg::C_LVL +: 3];
	// Merged high word is shared by the register and the store loads
	assign hi_merge = strb_fn({8'h00, hi_reg}, wd_reg, ws_reg);
	assign sel_merge = strb_fn({24'h0, sel_reg}, wd_reg, ws_reg);
	// Any installed register apart from the excluded reports
	assign ss_flag = |({inst_reg[4], inst_reg[3], inst_reg[2],
		inst_reg[1], inst_reg[0]} & ~dcr_pkg::SS_EXCL);

	// Report assembly; a failed link leaves no report at all
	always_comb begin
		report = 56'h0;
		report[dcr_pkg::R_LVL +: 3] = lvl;
		report[dcr_pkg::R_PEAK +: 4] = sync2_reg[7:4];
		report[dcr_pkg::R_AVG +: 4] = sync2_reg[3:0];
		report[dcr_pkg::R_CASP] = ctrl_reg[dcr_pkg::C_CASP];
		report[dcr_pkg::R_CASA] = ctrl_reg[dcr_pkg::C_CASA];
		report[dcr_pkg::R_CIRC] = ctrl_reg[dcr_pkg::C_CIRC];
		report[dcr_pkg::R_SS] = ss_flag;
		report[dcr_pkg::R_TERM +: 4] =
			ctrl_reg[dcr_pkg::C_TERM +: 4];
		report[dcr_pkg::R_VER +: 7] =
			ctrl_reg[dcr_pkg::C_VER +: 7];
		if (link_fail) begin
			report = 56'h0;
		end
	end

	// Announce each new report once, held until taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ann_reg <= 56'h0;
			bc_pend_reg <= 1'b0;
			bc_data_reg <= 56'h0;
		end else if (bc_pend_reg) begin
			if (bc_ready) begin
				bc_pend_reg <= 1'b0;
			end
		end else if (report != ann_reg) begin
			ann_reg <= report;
			bc_data_reg <= report;
			bc_pend_reg <= 1'b1;
		end
	end

	assign bc_valid = bc_pend_reg;
	assign bc_data = bc_data_reg;

	// Air reads see the store but can never change it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rp_valid_reg <= 1'b0;
			rp_reply_reg <= 1'b0;
			rp_data_reg <= 56'h0;
		end else begin
			rp_valid_reg <= ir_valid;
			if (ir_valid) begin
				rp_reply_reg <= ok_fn(ir_kind, lvl, ir_store_ok,
					ir_other_busy, ir_reg);
				if (ir_kind != dcr_pkg::K_RDREG || ir_reg == 8'h00) begin
					rp_data_reg <= 56'h0;
				end else if (ir_reg == dcr_pkg::REG_CAP) begin
					rp_data_reg <= report;
				end else begin
					rp_data_reg <= mem[ir_reg];
				end
			end
		end
	end

	assign rp_valid = rp_valid_reg;
	assign rp_reply = rp_reply_reg;
	assign rp_data = rp_data_reg;

	// Software loads a register from the staged words on a high write.
	// Register 10 is built by hardware, so loads to it are dropped.
	always_ff @(posedge clk) begin
		if (do_wr && aw_reg == dcr_pkg::ADR_HI && sel_reg != 8'h00
			&& sel_reg != dcr_pkg::REG_CAP) begin
			// Flags for 17, 18 to 1C, 1D to 1F load like any other
			mem[sel_reg] <= {hi_merge[23:0],
				lo_reg};
		end
	end

	// Installed-flag shadow feeds the specific-services bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 5; i++) begin
				inst_reg[i] <= 56'h0;
			end
		end else if (do_wr && aw_reg == dcr_pkg::ADR_HI
			&& sel_reg >= dcr_pkg::REG_INST0
			&& sel_reg <= dcr_pkg::REG_INST4) begin
			inst_reg[3'(sel_reg - dcr_pkg::REG_INST0)] <= {hi_merge[23:0],
				lo_reg};
		end
	end

	// AXI write channels are taken independently
	assign do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready = !w_have_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_reg <= 8'h00;
			wd_reg <= 32'h0;
			ws_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= dcr_pkg::RSP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wd_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				// Read-only and unmapped offsets answer with an error
				bresp_reg <= (aw_reg == dcr_pkg::ADR_CTRL
					|| aw_reg == dcr_pkg::ADR_SEL
					|| aw_reg == dcr_pkg::ADR_LO
					|| aw_reg == dcr_pkg::ADR_HI)
					? dcr_pkg::RSP_OK : dcr_pkg::RSP_ERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Writable registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= dcr_pkg::CTRL_RST;
			sel_reg <= 8'h00;
			lo_reg <= 32'h0;
			hi_reg <= 24'h0;
		end else if (do_wr) begin
			unique case (aw_reg)
				dcr_pkg::ADR_CTRL: begin
					ctrl_reg <= strb_fn(ctrl_reg, wd_reg, ws_reg);
				end
				dcr_pkg::ADR_SEL: sel_reg <= sel_merge[7:0];
				dcr_pkg::ADR_LO: begin
					lo_reg <= strb_fn(lo_reg, wd_reg, ws_reg);
				end
				dcr_pkg::ADR_HI: hi_reg <= hi_merge[23:0];
				default: ;
			endcase
		end
	end

	// Read channel answers one cycle after the address is taken
	assign s_axi_arready = !rvalid_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= dcr_pkg::RSP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= dcr_pkg::RSP_OK;
			unique case (s_axi_araddr)
				dcr_pkg::ADR_CTRL: rdata_reg <= ctrl_reg;
				dcr_pkg::ADR_STAT: begin
					rdata_reg <= {26'h0, lvl, ss_flag, bc_pend_reg,
						link_fail};
				end
				dcr_pkg::ADR_SEL: rdata_reg <= {24'h0, sel_reg};
				dcr_pkg::ADR_LO: rdata_reg <= lo_reg;
				dcr_pkg::ADR_HI: rdata_reg <= {8'h00, hi_reg};
				dcr_pkg::ADR_RATE: rdata_reg <= {24'h0, sync2_reg[7:0]};
				default: begin
					rdata_reg <= 32'h0;
					rresp_reg <= dcr_pkg::RSP_ERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_change;
		!bc_valid && report != ann_reg;
	endsequence
	sequence s_offer;
		bc_valid && bc_data == $past(report);
	endsequence

	a_bc_on_change: assert property (s_change |=> s_offer)
		else $error("report change not offered");
	a_bc_once: assert property (bc_valid && bc_ready
		|=> !bc_valid)
		else $error("broadcast repeated");
	a_bc_hold: assert property (bc_valid && !bc_ready
		|=> bc_valid && $stable(bc_data))
		else $error("broadcast dropped before taken");
	a_fail_empty: assert property (link_fail
		|-> report == 56'h0)
		else $error("report present on link failure");
	a_short_low: assert property (ir_valid
		&& ir_kind == dcr_pkg::K_SHORT_DN && lvl < dcr_pkg::LVL_2
		|=> rp_valid && !rp_reply)
		else $error("short message served below level two");
	a_ext_up_low: assert property (ir_valid
		&& ir_kind == dcr_pkg::K_EXT_UP && lvl < dcr_pkg::LVL_3
		|=> rp_valid && !rp_reply)
		else $error("extended uplink served below level three");
	a_ext_dn_low: assert property (ir_valid
		&& ir_kind == dcr_pkg::K_EXT_DN && lvl < dcr_pkg::LVL_4
		|=> !rp_reply)
		else $error("extended downlink served below level four");
	a_busy_multi: assert property (ir_valid
		&& ir_kind == dcr_pkg::K_SHORT_DN && ir_other_busy
		&& lvl == dcr_pkg::LVL_4 |=> !rp_reply)
		else $error("concurrent link served below level five");
	a_store_full: assert property (ir_valid
		&& ir_kind == dcr_pkg::K_SHORT_UP && !ir_store_ok
		|=> rp_valid && !rp_reply)
		else $error("uplink accepted with no storage");
	a_ss_flag: assert property (!link_fail
		|-> report[dcr_pkg::R_SS] == |({inst_reg[4], inst_reg[3],
		inst_reg[2], inst_reg[1], inst_reg[0]} & ~dcr_pkg::SS_EXCL))
		else $error("specific services bit wrong");
	a_cap_read: assert property (ir_valid
		&& ir_kind == dcr_pkg::K_RDREG && ir_reg == dcr_pkg::REG_CAP
		|=> rp_reply && rp_data == $past(report))
		else $error("capability read wrong");
endmodule

// ==== sim/dcr_partner.sv ====
`timescale 1ns/100ps
// Ground side of the broadcast channel, can stall before taking
module dcr_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bc_valid,
	input wire logic [55:0] bc_data,
	input wire logic [3:0] delay,
	output logic bc_ready,
	output logic [55:0] got,
	output logic [7:0] cnt
);
	logic [3:0] wt; // Cycles the current offer has waited
	// Ready only while an offer stands, so no offer is ever pre-accepted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bc_ready <= 1'b0;
			got <= '0;
			cnt <= 8'h00;
			wt <= 4'h0;
		end else if (bc_valid && bc_ready) begin
			got <= bc_data;
			cnt <= cnt + 8'h01;
			bc_ready <= 1'b0;
			wt <= 4'h0;
		end else if (bc_valid) begin
			wt <= wt + 4'h1;
			bc_ready <= (wt >= delay);
		end
	end
endmodule

// ==== sim/datalink_capability_report_bench.sv ====
`timescale 1ns/100ps
// Drives bus and air side, checks replies, report and broadcasts
module datalink_capability_report_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0, ir_reg = '0, cnt;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata, d, ctrl = '0;
	logic [3:0] wstrb = 4'hf, pk = '0, avr = '0, dly = '0;
	logic lf = 0, ir_valid = 0, busy = 0, sto = 1, ss = 0;
	logic [2:0] ir_kind = '0;
	logic awready, wready, bvalid, arready, rvalid, rp_valid, rp_reply;
	logic bc_valid, bc_ready, rep_ok, eo;
	logic [1:0] bresp, rresp, r;
	logic [55:0] rp_data, bc_data, got, rd56;
	logic [7:0] rl [4] = '{8'h17, 8'h1d, 8'h1f, 8'h40};
	int fail_count = 0, check_count = 0, exp_n = 0;
	always #4 clk = ~clk;
	dcr_top u_dut (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rate_peak_pin(pk), .rate_avg_pin(avr), .link_fail_pin(lf),
		.ir_valid(ir_valid), .ir_kind(ir_kind), .ir_reg(ir_reg),
		.ir_other_busy(busy), .ir_store_ok(sto), .rp_valid(rp_valid),
		.rp_reply(rp_reply), .rp_data(rp_data), .bc_valid(bc_valid),
		.bc_data(bc_data), .bc_ready(bc_ready));
	dcr_partner u_gnd (.clk(clk), .rst_n(rst_n), .bc_valid(bc_valid),
		.bc_data(bc_data), .delay(dly), .bc_ready(bc_ready), .got(got),
		.cnt(cnt));
	// Expected report from what the bench has set; link loss zeroes it
	function automatic logic [55:0] rep();
		logic [55:0] x;
		x = '0;
		if (!lf) begin
			x[dcr_pkg::R_LVL +: 3] = ctrl[2:0];
			x[dcr_pkg::R_PEAK +: 4] = pk;
			x[dcr_pkg::R_AVG +: 4] = avr;
			x[dcr_pkg::R_CASP] = ctrl[4];
			x[dcr_pkg::R_CASA] = ctrl[5];
			x[dcr_pkg::R_CIRC] = ctrl[6];
			x[dcr_pkg::R_SS] = ss;
			x[dcr_pkg::R_TERM +: 4] = ctrl[11:8];
			x[dcr_pkg::R_VER +: 7] = ctrl[22:16];
		end
		return x;
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic ckd(input logic [55:0] g, input logic [55:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 40 && !tb; n++) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic axr(input logic [7:0] a);
		logic ta, tr;
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		for (n = 0; n < 40 && !tr; n++) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			r = rresp;
			d = rdata;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		if (!tr) begin
			fail_count++;
			wrap_up();
		end
	endtask
	// One interrogation; the reply strobe stands one cycle only
	task automatic air(input logic [2:0] k, input logic [7:0] g);
		@(posedge clk);
		ir_valid <= 1'b1;
		ir_kind <= k;
		ir_reg <= g;
		@(posedge clk);
		ir_valid <= 1'b0;
		@(negedge clk);
		ckd(56'(rp_valid), 56'h1);
		rep_ok = rp_reply;
		rd56 = rp_data;
	endtask
	task automatic ldreg(input logic [7:0] n, input logic [55:0] v);
		axw(dcr_pkg::ADR_SEL, 32'(n));
		axw(dcr_pkg::ADR_LO, v[31:0]);
		axw(dcr_pkg::ADR_HI, {8'h00, v[55:32]});
		ckd(56'(r), 56'(dcr_pkg::RSP_OK));
	endtask
	// Next offer must carry the new report, and only one per change
	task automatic wait_bc();
		int n;
		exp_n++;
		for (n = 0; n < 60 && cnt !== 8'(exp_n); n++) @(negedge clk);
		if (n == 60) begin
			fail_count++;
			wrap_up();
		end
		ckd(got, rep());
		repeat (8) @(posedge clk);
		ckd(56'(cnt), 56'(exp_n));
	endtask
	task automatic setc(input logic [31:0] c);
		ctrl = c;
		axw(dcr_pkg::ADR_CTRL, c);
		wait_bc();
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		axr(dcr_pkg::ADR_CTRL);
		ckd(56'(d), 56'(dcr_pkg::CTRL_RST));
		pk <= 4'h9;
		avr <= 4'h3;
		wait_bc();
		axr(dcr_pkg::ADR_RATE);
		ckd(56'(d), 56'h93);
		setc(32'h002a_0554);
		air(dcr_pkg::K_RDREG, dcr_pkg::REG_CAP);
		ckd(rd56, rep());
		// Only an excluded register flagged: no specific service yet
		ldreg(dcr_pkg::REG_INST0, 56'h1_0000);
		axr(dcr_pkg::ADR_STAT);
		ckd(56'(d[2]), 56'h0);
		ss = 1'b1;
		ldreg(dcr_pkg::REG_INST0, 56'h80_0000);
		wait_bc();
		axr(dcr_pkg::ADR_STAT);
		ckd(56'(d[2]), 56'h1);
		for (int i = 0; i < 4; i++) begin
			ldreg(rl[i], {rl[i], 48'h1234_5678_9abc});
			air(dcr_pkg::K_RDREG, rl[i]);
			ckd(rd56, {rl[i], 48'h1234_5678_9abc});
		end
		// Levels one to five against every air kind except register read
		for (int i = 1; i < 6; i++) begin
			setc(32'(i));
			for (int k = 0; k < 5; k++) begin
				air(3'(k), 8'h00);
				eo = k == 0 || (k < 3 ? i >= 2 : i >= k);
				ckd(56'(rep_ok), 56'(eo));
			end
		end
		air(3'h6, 8'h00);
		ckd(56'(rep_ok), 56'h0);
		air(dcr_pkg::K_RDREG, 8'h00);
		ckd(56'(rep_ok), 56'h0);
		busy <= 1'b1;
		air(dcr_pkg::K_EXT_DN, 8'h00);
		ckd(56'(rep_ok), 56'h1);
		setc(32'h4);
		air(dcr_pkg::K_SHORT_DN, 8'h00);
		ckd(56'(rep_ok), 56'h0);
		busy <= 1'b0;
		sto <= 1'b0;
		air(dcr_pkg::K_SHORT_UP, 8'h00);
		ckd(56'(rep_ok), 56'h0);
		air(dcr_pkg::K_EXT_UP, 8'h00);
		ckd(56'(rep_ok), 56'h0);
		air(dcr_pkg::K_SHORT_DN, 8'h00);
		ckd(56'(rep_ok), 56'h1);
		// Interrogator falls back to surveillance, then retries
		air(dcr_pkg::K_SURV, 8'h00);
		ckd(56'(rep_ok), 56'h1);
		sto <= 1'b1;
		air(dcr_pkg::K_SHORT_UP, 8'h00);
		ckd(56'(rep_ok), 56'h1);
		axw(dcr_pkg::ADR_STAT, 32'hffff_ffff);
		ckd(56'(r), 56'(dcr_pkg::RSP_ERR));
		axw(8'h20, 32'h0000_0007);
		ckd(56'(r), 56'(dcr_pkg::RSP_ERR));
		axr(8'h20);
		ckd(56'({r, d}), 56'({dcr_pkg::RSP_ERR, 32'h0}));
		axr(dcr_pkg::ADR_CTRL);
		ckd(56'(d), 56'(ctrl));
		// Processor link lost with a slow ground side, then restored
		dly <= 4'h4;
		lf <= 1'b1;
		wait_bc();
		axr(dcr_pkg::ADR_STAT);
		ckd(56'(d[0]), 56'h1);
		lf <= 1'b0;
		wait_bc();
		wrap_up();
	end
endmodule
